// >>> design/fnd_pkg.sv
// Shared constants and types for the fractional-N divider core
package fnd_pkg;
  localparam int WHOLE_W = 8;
  localparam int NUMERATOR_VALUE_W  = 12;
  localparam int RDIV_W  = 4;
  localparam int TMR_W   = 10;
  localparam int CELL_W  = 7;
  localparam int CELLS   = 64;
  localparam int SWAL_W  = 3;
  localparam int MAIN_W  = 6;

  localparam logic [WHOLE_W-1:0] N_MIN          = 8'h1A;
  localparam logic [WHOLE_W-1:0] N_MAX          = 8'hFF;
  localparam logic [WHOLE_W-1:0] N_HI_ABOVE     = 8'h50;
  localparam logic [3:0]         PRESC_LO       = 4'h4;
  localparam logic [3:0]         PRESC_HI       = 4'h8;
  localparam int                 SHIFT_LO       = 2;
  localparam int                 SHIFT_HI       = 3;
  localparam logic [1:0]         TMR_PRE_LAST   = 2'h3;
  localparam logic [CELL_W-1:0]  CELLS_FULL     = 7'h40;
  localparam logic [CELL_W-1:0]  CELLS_ONE      = 7'h01;
  localparam logic [RDIV_W-1:0]  RDIV_ONE       = 4'h1;

  // Programming word; reference fields act at once, the rest on a load strobe
  typedef struct packed {
    logic [WHOLE_W-1:0] whole_part;
    logic [NUMERATOR_VALUE_W-1:0]  numerator_value;
    logic [NUMERATOR_VALUE_W-1:0]  denominator_value;
    logic [RDIV_W-1:0]  ref_div;
    logic               ref_toggle;
    logic               ref_doubler;
    logic               presc_hi_sel;
    logic [TMR_W-1:0]   pump_current_timer;
  } fnd_cfg_t;

  // Fast-lock phases
  typedef enum logic [2:0] {
    FL_NORMAL = 3'b001,
    FL_TIMING = 3'b010,
    FL_STEP   = 3'b100
  } fnd_fl_t;
endpackage : fnd_pkg

// >>> design/fnd_accum.sv
// Modulo accumulator stage of the sigma-delta modulator
`timescale 1ns/1ps
module fnd_accum
  import fnd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              step,
  input  wire logic [NUMERATOR_VALUE_W-1:0] addend,
  input  wire logic [NUMERATOR_VALUE_W-1:0] modulus,
  output logic      [NUMERATOR_VALUE_W-1:0] sum_reg,
  output logic                   carry_reg
);
  logic [NUMERATOR_VALUE_W:0]   wide;
  logic [NUMERATOR_VALUE_W-1:0] sum_next;
  logic              carry_next;

  // Add, wrap at the modulus, flag the wrap
  always_comb begin
    wide       = {1'b0, sum_reg} + {1'b0, addend};
    sum_next   = sum_reg;
    carry_next = carry_reg;
    if (step) begin
      carry_next = (wide >= {1'b0, modulus}) && (modulus != '0);
      sum_next   = carry_next ? NUMERATOR_VALUE_W'(wide - {1'b0, modulus})
                              : wide[NUMERATOR_VALUE_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sum_reg   <= '0;
      carry_reg <= 1'b0;
    end else begin
      sum_reg   <= sum_next;
      carry_reg <= carry_next;
    end
  end

  property p_acc_bound;
    @(posedge core_clk) disable iff (sys_rst)
      step && addend < modulus && sum_reg < modulus |=> sum_reg < modulus;
  endproperty
  a_acc_bound: assert property (p_acc_bound)
    else $error("accumulator left modulus range");
endmodule : fnd_accum

// >>> design/fnd_pfd.sv
// Tri-state phase-frequency detector
`timescale 1ns/1ps
module fnd_pfd (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic ref_evt,
  input  wire logic fb_evt,
  output logic      up_reg,
  output logic      dn_reg
);
  logic up_next;
  logic dn_next;

  // Set on each edge, clear both once both are up
  always_comb begin
    if (up_reg && dn_reg) begin
      up_next = 1'b0;
      dn_next = 1'b0;
    end else begin
      up_next = up_reg | ref_evt;
      dn_next = dn_reg | fb_evt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      up_reg <= up_next;
      dn_reg <= dn_next;
    end
  end

  sequence s_both;
    up_reg && dn_reg;
  endsequence
  sequence s_idle;
    !up_reg && !dn_reg;
  endsequence

  property p_clear;
    @(posedge core_clk) disable iff (sys_rst) s_both |=> s_idle;
  endproperty
  a_clear: assert property (p_clear)
    else $error("detector outputs not cleared together");

  property p_up_first;
    @(posedge core_clk) disable iff (sys_rst)
      s_idle ##0 ref_evt && !fb_evt |=> up_reg && !dn_reg;
  endproperty
  a_up_first: assert property (p_up_first)
    else $error("lagging feedback gave no up pulse");

  property p_dn_first;
    @(posedge core_clk) disable iff (sys_rst)
      s_idle ##0 fb_evt && !ref_evt |=> dn_reg && !up_reg;
  endproperty
  a_dn_first: assert property (p_dn_first)
    else $error("leading feedback gave no down pulse");
endmodule : fnd_pfd

// >>> design/fnd_top.sv
// Reference path, feedback divider, modulator, detector and fast lock
`timescale 1ns/1ps
// Overview of operation
// - Reference falling edge is the active reference event.
// - A 4-bit divider divides the reference down to the comparison clock.
// - Optional toggle stage halves it again for a 50 percent duty cycle.
// - Timer clock from comparison falling edge; detector uses rising edge.
// - Optional doubler ahead of the divider, for references up to 20 MHz.
// - Overall reference division spans 1 to 30; a divider value of 1 gives comparison edges only with the toggle stage.
// - Prescaler offers 4/5 and 8/9; 8/9 used for divide values above 80.
// - Feedback integer divide range is 26 through 255.
// - Third-order sigma-delta modulator varies the integer divide value.
// - Division is whole part plus numerator over denominator, stored apart.
// - Detector compares both divided clocks into up and down pulses.
// - Lagging feedback gives net up; leading feedback gives net down.
// - 64 pump cells; all on while the fast-lock timer runs, one in normal operation.
// - Power-down unloads the reference pin; leaving it restores switches.
// - Fast-lock timer advances at a quarter of the comparison rate.
// - Load enables 64 cells; after timeout halve cells over six ticks.
module fnd_top
  import fnd_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             reference_clock_input,
  input  wire logic             vco_feedback_input,
  input  wire fnd_cfg_t         cfg,
  input  wire logic             new_freq_load,
  input  wire logic             power_down,
  output logic                  pump_up_reg,
  output logic                  pump_dn_reg,
  output logic [CELLS-1:0]      cell_en_reg,
  output logic [CELL_W-1:0]     cell_count_reg,
  output logic                  fast_lock_reg,
  output logic                  cmp_clk_reg,
  output logic                  ref_path_closed_reg,
  output logic                  ref_shunt_closed_reg
);
  // Pin synchronisers and edge history
  logic [2:0] ref_sync_reg;
  logic [2:0] fb_sync_reg;
  logic       ref_fall;
  logic       ref_rise;
  logic       ref_evt;
  logic       fb_evt;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ref_sync_reg <= '0;
      fb_sync_reg  <= '0;
    end else begin
      ref_sync_reg <= {ref_sync_reg[1:0], reference_clock_input};
      fb_sync_reg  <= {fb_sync_reg[1:0], vco_feedback_input};
    end
  end

  // Reference events, doubled by taking both edges
  always_comb begin
    ref_fall = ref_sync_reg[2] && !ref_sync_reg[1];
    ref_rise = !ref_sync_reg[2] && ref_sync_reg[1];
    ref_evt  = !power_down &&
               (ref_fall || (cfg.ref_doubler && ref_rise));
    fb_evt   = !power_down && !fb_sync_reg[2] && fb_sync_reg[1];
  end

  // Reference divider and comparison clock
  logic [RDIV_W-1:0] rcnt_reg;
  logic [RDIV_W-1:0] rcnt_next;
  logic [RDIV_W-1:0] rdiv_eff;
  logic              rdiv_pulse;
  logic              cmp_clk_next;
  logic              cmp_d_reg;
  logic              cmp_rise;
  logic              cmp_fall;

  always_comb begin
    rdiv_eff     = (cfg.ref_div == '0) ? RDIV_ONE : cfg.ref_div;
    rdiv_pulse   = ref_evt && (rcnt_reg >= rdiv_eff - RDIV_ONE);
    rcnt_next    = rcnt_reg;
    cmp_clk_next = cmp_clk_reg;
    if (ref_evt) begin
      rcnt_next = rdiv_pulse ? '0 : rcnt_reg + RDIV_ONE;
    end
    if (cfg.ref_toggle) begin
      cmp_clk_next = cmp_clk_reg ^ rdiv_pulse;
    end else if (rdiv_pulse) begin
      cmp_clk_next = 1'b1;
    end else if (ref_evt) begin
      cmp_clk_next = 1'b0;
    end
    cmp_rise = cmp_clk_reg && !cmp_d_reg;
    cmp_fall = !cmp_clk_reg && cmp_d_reg;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rcnt_reg    <= '0;
      cmp_clk_reg <= 1'b0;
      cmp_d_reg   <= 1'b0;
    end else begin
      rcnt_reg    <= rcnt_next;
      cmp_clk_reg <= cmp_clk_next;
      cmp_d_reg   <= cmp_clk_reg;
    end
  end

  // Programmed division, whole and fraction held apart
  logic [WHOLE_W-1:0] whole_reg;
  logic [NUMERATOR_VALUE_W-1:0]  num_reg;
  logic [NUMERATOR_VALUE_W-1:0]  den_reg;
  logic               hi_sel_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      whole_reg  <= N_MIN;
      num_reg    <= '0;
      den_reg    <= '0;
      hi_sel_reg <= 1'b0;
    end else if (new_freq_load) begin
      whole_reg  <= cfg.whole_part;
      num_reg    <= cfg.numerator_value;
      den_reg    <= cfg.denominator_value;
      hi_sel_reg <= cfg.presc_hi_sel;
    end
  end

  // Third-order modulator: three chained accumulators
  logic              fb_done_reg;
  logic [NUMERATOR_VALUE_W-1:0] s1;
  logic [NUMERATOR_VALUE_W-1:0] s2;
  logic [NUMERATOR_VALUE_W-1:0] s3;
  logic              c1;
  logic              c2;
  logic              c3;
  logic              c2d_reg;
  logic              c3d_reg;
  logic              c3dd_reg;

  fnd_accum u_acc1 (.core_clk(core_clk), .sys_rst(sys_rst),
    .step(fb_done_reg), .addend(num_reg), .modulus(den_reg),
    .sum_reg(s1), .carry_reg(c1));
  fnd_accum u_acc2 (.core_clk(core_clk), .sys_rst(sys_rst),
    .step(fb_done_reg), .addend(s1), .modulus(den_reg),
    .sum_reg(s2), .carry_reg(c2));
  fnd_accum u_acc3 (.core_clk(core_clk), .sys_rst(sys_rst),
    .step(fb_done_reg), .addend(s2), .modulus(den_reg),
    .sum_reg(s3), .carry_reg(c3));

  // Carry history for the noise-shaping differences
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      c2d_reg  <= 1'b0;
      c3d_reg  <= 1'b0;
      c3dd_reg <= 1'b0;
    end else if (fb_done_reg) begin
      c2d_reg  <= c2;
      c3d_reg  <= c3;
      c3dd_reg <= c3d_reg;
    end
  end

  // Instantaneous divide value and prescaler split
  logic signed [3:0]   delta;
  logic signed [9:0]   n_raw;
  logic [WHOLE_W-1:0]  n_sel;
  logic                hi_now;
  logic [SWAL_W-1:0]   a_load;
  logic [MAIN_W-1:0]   b_load;

  always_comb begin
    delta = $signed({3'b000, c1}) + $signed({3'b000, c2})
          - $signed({3'b000, c2d_reg}) + $signed({3'b000, c3})
          - $signed({2'b00, c3d_reg, 1'b0})
          + $signed({3'b000, c3dd_reg});
    n_raw = $signed({2'b00, whole_reg}) + $signed({{6{delta[3]}}, delta});
    if (n_raw < $signed({2'b00, N_MIN})) begin
      n_sel = N_MIN;
    end else if (n_raw > $signed({2'b00, N_MAX})) begin
      n_sel = N_MAX;
    end else begin
      n_sel = n_raw[WHOLE_W-1:0];
    end
    hi_now = hi_sel_reg || (n_sel > N_HI_ABOVE);
    if (hi_now) begin
      a_load = n_sel[SHIFT_HI-1:0];
      b_load = MAIN_W'(n_sel >> SHIFT_HI);
    end else begin
      a_load = SWAL_W'(n_sel[SHIFT_LO-1:0]);
      b_load = MAIN_W'(n_sel >> SHIFT_LO);
    end
  end

  // Dual-modulus prescaler with swallow and main counters
  logic [3:0]        pcnt_reg;
  logic [3:0]        pcnt_next;
  logic [SWAL_W-1:0] swal_reg;
  logic [SWAL_W-1:0] swal_next;
  logic [MAIN_W-1:0] main_reg;
  logic [MAIN_W-1:0] main_next;
  logic              phi_reg;
  logic              phi_next;
  logic              fb_done_next;
  logic [3:0]        pmod;

  always_comb begin
    pmod = phi_reg ? PRESC_HI : PRESC_LO;
    if (swal_reg != '0) begin
      pmod = pmod + 4'h1;
    end
    pcnt_next    = pcnt_reg;
    swal_next    = swal_reg;
    main_next    = main_reg;
    phi_next     = phi_reg;
    fb_done_next = 1'b0;
    if (fb_evt) begin
      pcnt_next = pcnt_reg + 4'h1;
      if (pcnt_reg + 4'h1 >= pmod) begin
        pcnt_next = '0;
        if (swal_reg != '0) begin
          swal_next = swal_reg - SWAL_W'(1);
        end
        if (main_reg <= MAIN_W'(1)) begin
          fb_done_next = 1'b1;
          main_next    = b_load;
          swal_next    = a_load;
          phi_next     = hi_now;
        end else begin
          main_next = main_reg - MAIN_W'(1);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pcnt_reg    <= '0;
      swal_reg    <= '0;
      main_reg    <= '0;
      phi_reg     <= 1'b0;
      fb_done_reg <= 1'b0;
    end else begin
      pcnt_reg    <= pcnt_next;
      swal_reg    <= swal_next;
      main_reg    <= main_next;
      phi_reg     <= phi_next;
      fb_done_reg <= fb_done_next;
    end
  end

  // Detector on comparison rising edge and divided feedback
  fnd_pfd u_pfd (.core_clk(core_clk), .sys_rst(sys_rst),
    .ref_evt(cmp_rise), .fb_evt(fb_done_reg),
    .up_reg(pump_up_reg), .dn_reg(pump_dn_reg));

  // Fast-lock timer and cell stepping
  fnd_fl_t            fl_reg;
  fnd_fl_t            fl_next;
  logic [1:0]         tpre_reg;
  logic [1:0]         tpre_next;
  logic [TMR_W-1:0]   tmr_reg;
  logic [TMR_W-1:0]   tmr_next;
  logic [CELL_W-1:0]  cells_next;
  logic [CELLS-1:0]   en_next;
  logic               tick;

  always_comb begin
    tick       = cmp_fall && (tpre_reg == TMR_PRE_LAST);
    tpre_next  = cmp_fall ? tpre_reg + 2'h1 : tpre_reg;
    fl_next    = fl_reg;
    tmr_next   = tmr_reg;
    cells_next = cell_count_reg;
    if (new_freq_load) begin
      fl_next    = FL_TIMING;
      tmr_next   = cfg.pump_current_timer;
      cells_next = CELLS_FULL;
    end else begin
      unique case (fl_reg)
        FL_NORMAL: cells_next = CELLS_ONE;
        FL_TIMING: begin
          if (tick) begin
            if (tmr_reg == '0) begin
              fl_next    = FL_STEP;
              cells_next = cell_count_reg >> 1;
            end else begin
              tmr_next = tmr_reg - TMR_W'(1);
            end
          end
        end
        FL_STEP: begin
          if (tick) begin
            cells_next = cell_count_reg >> 1;
          end
          if (cells_next <= CELLS_ONE) begin
            fl_next    = FL_NORMAL;
            cells_next = CELLS_ONE;
          end
        end
        default: begin
          fl_next    = FL_NORMAL;
          cells_next = CELLS_ONE;
        end
      endcase
    end
    for (int i = 0; i < CELLS; i++) begin
      en_next[i] = (i < int'(cells_next));
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fl_reg         <= FL_NORMAL;
      tpre_reg       <= '0;
      tmr_reg        <= '0;
      cell_count_reg <= CELLS_ONE;
      cell_en_reg    <= CELLS'(1);
      fast_lock_reg  <= 1'b0;
    end else begin
      fl_reg         <= fl_next;
      tpre_reg       <= tpre_next;
      tmr_reg        <= tmr_next;
      cell_count_reg <= cells_next;
      cell_en_reg    <= en_next;
      fast_lock_reg  <= (fl_next != FL_NORMAL);
    end
  end

  // Reference input switches follow power-down
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ref_path_closed_reg  <= 1'b1;
      ref_shunt_closed_reg <= 1'b0;
    end else begin
      ref_path_closed_reg  <= !power_down;
      ref_shunt_closed_reg <= power_down;
    end
  end

  property p_rise_ignored;
    @(posedge core_clk) disable iff (sys_rst)
      ref_rise && !cfg.ref_doubler |=> $stable(rcnt_reg);
  endproperty
  a_rise_ignored: assert property (p_rise_ignored)
    else $error("rising reference edge moved the divider");

  property p_rdiv_wrap;
    @(posedge core_clk) disable iff (sys_rst)
      ref_evt && rcnt_reg == rdiv_eff - RDIV_ONE |=> rcnt_reg == '0;
  endproperty
  a_rdiv_wrap: assert property (p_rdiv_wrap)
    else $error("reference divider did not wrap");

  property p_toggle;
    @(posedge core_clk) disable iff (sys_rst)
      rdiv_pulse && cfg.ref_toggle |=> cmp_clk_reg != $past(cmp_clk_reg);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle stage did not flip");

  property p_quarter;
    @(posedge core_clk) disable iff (sys_rst)
      cmp_fall |=> tpre_reg == $past(tpre_reg) + 2'h1;
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("timer prescale missed a falling edge");

  sequence s_load;
    new_freq_load;
  endsequence
  sequence s_all_on;
    cell_count_reg == CELLS_FULL && (&cell_en_reg) && fast_lock_reg;
  endsequence
  property p_load_full;
    @(posedge core_clk) disable iff (sys_rst) s_load |=> s_all_on;
  endproperty
  a_load_full: assert property (p_load_full)
    else $error("load did not enable all cells");

  property p_halve;
    @(posedge core_clk) disable iff (sys_rst)
      fl_reg == FL_STEP && tick && !new_freq_load
        && cell_count_reg > CELLS_ONE
      |=> cell_count_reg == ($past(cell_count_reg) >> 1);
  endproperty
  a_halve: assert property (p_halve)
    else $error("cell count not halved on timer tick");

  property p_normal_one;
    @(posedge core_clk) disable iff (sys_rst)
      !fast_lock_reg |-> cell_en_reg == CELLS'(1);
  endproperty
  a_normal_one: assert property (p_normal_one)
    else $error("normal operation without exactly one cell");

  property p_pd;
    @(posedge core_clk) disable iff (sys_rst)
      power_down |=> ref_shunt_closed_reg && !ref_path_closed_reg;
  endproperty
  a_pd: assert property (p_pd)
    else $error("reference pin still loaded in power-down");

  property p_hi_presc;
    @(posedge core_clk) disable iff (sys_rst)
      fb_done_next && n_sel > N_HI_ABOVE |=> phi_reg;
  endproperty
  a_hi_presc: assert property (p_hi_presc)
    else $error("8/9 prescaler not used above 80");

  property p_n_range;
    @(posedge core_clk) disable iff (sys_rst)
      fb_done_next |-> n_sel >= N_MIN;
  endproperty
  a_n_range: assert property (p_n_range)
    else $error("feedback divide below minimum");
endmodule : fnd_top

// >>> verification/fnd_src_model.sv
// Reference and feedback edge sources facing the divider core
`timescale 1ns/1ps
module fnd_src_model (
  input  wire logic   core_clk,
  input  wire integer ref_half,
  input  wire integer fb_half,
  output logic        ref_pin,
  output logic        fb_pin
);
  int ref_cnt;
  int fb_cnt;

  // Pins move 2 ns after a core edge; each level lasts whole cycles
  initial begin
    ref_pin = 1'b1;
    fb_pin  = 1'b0;
    ref_cnt = 0;
    fb_cnt  = 0;
    forever begin
      @(posedge core_clk);
      #2;
      ref_cnt++;
      fb_cnt++;
      // Oscillator kept slow enough for the doubler
      if (ref_half > 0 && ref_cnt >= ref_half) begin
        ref_pin = ~ref_pin;
        ref_cnt = 0;
      end
      // Edges at the prescaler input rate
      if (fb_half > 0 && fb_cnt >= fb_half) begin
        fb_pin = ~fb_pin;
        fb_cnt = 0;
      end
    end
  end
endmodule : fnd_src_model

// >>> verification/fractional_n_divider_pfd_tb.sv
// Self-checking bench for the fractional-N divider core
`timescale 1ns/1ps
module fractional_n_divider_pfd_tb
  import fnd_pkg::*;
;
  logic              core_clk, sys_rst, ref_pin, fb_pin;
  fnd_cfg_t          cfg;
  logic              new_freq_load, power_down, pump_up_reg, pump_dn_reg;
  logic [CELLS-1:0]  cell_en_reg;
  logic [CELL_W-1:0] cell_count_reg;
  logic              fast_lock_reg, cmp_clk_reg;
  logic              ref_path_closed_reg, ref_shunt_closed_reg;
  int                ref_half, fb_half, num_errors, checked;

  fnd_top dut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .reference_clock_input(ref_pin), .vco_feedback_input(fb_pin),
    .cfg(cfg), .new_freq_load(new_freq_load), .power_down(power_down),
    .pump_up_reg(pump_up_reg), .pump_dn_reg(pump_dn_reg),
    .cell_en_reg(cell_en_reg), .cell_count_reg(cell_count_reg),
    .fast_lock_reg(fast_lock_reg), .cmp_clk_reg(cmp_clk_reg),
    .ref_path_closed_reg(ref_path_closed_reg),
    .ref_shunt_closed_reg(ref_shunt_closed_reg)
  );
  fnd_src_model src (
    .core_clk(core_clk), .ref_half(ref_half), .fb_half(fb_half),
    .ref_pin(ref_pin), .fb_pin(fb_pin)
  );

  // Core clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic complete_run();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic expect_ok(input logic bad, input string msg);
    checked++;
    if (bad !== 1'b0) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : expect_ok

  task automatic load();
    new_freq_load = 1'b1;
    tick(1);
    new_freq_load = 1'b0;
  endtask : load

  // Feedback edges counted up to the next rising down pulse
  task automatic dn_gap(output int edges);
    logic fq, dq;
    edges = 0;
    fq = fb_pin;
    dq = pump_dn_reg;
    for (int i = 0; i < 6000; i++) begin
      tick(1);
      if (fb_pin && !fq) edges++;
      if (pump_dn_reg === 1'b1 && dq === 1'b0) return;
      fq = fb_pin;
      dq = pump_dn_reg;
    end
    expect_ok(1'b1, "no down pulse");
    complete_run();
  endtask : dn_gap

  task automatic t_ref(input logic [RDIV_W-1:0] dv, input logic tg,
                       input logic db, input int exp_r);
    int rises, hi, since;
    logic cq, rq;
    cfg.ref_div = dv;
    cfg.ref_toggle = tg;
    cfg.ref_doubler = db;
    since = 99;
    rq = ref_pin;
    // Settle while tracking falls, so the first change is judged fairly
    for (int i = 0; i < 64; i++) begin
      tick(1);
      since = (rq && !ref_pin) ? 0 : since + 1;
      rq = ref_pin;
    end
    rises = 0;
    hi = 0;
    cq = cmp_clk_reg;
    for (int i = 0; i < 1920; i++) begin
      tick(1);
      since = (rq && !ref_pin) ? 0 : since + 1;
      if (cmp_clk_reg === 1'b1 && cq === 1'b0) rises++;
      if (cmp_clk_reg === 1'b1) hi++;
      if (tg && !db && cmp_clk_reg !== cq)
        expect_ok(since < 1 || since > 3, "cmp not after fall");
      cq = cmp_clk_reg;
      rq = ref_pin;
    end
    expect_ok(rises < exp_r - 1 || rises > exp_r + 1, "cmp rate");
    if (tg) expect_ok(hi * 2 - 1920 > 16 * dv + 16 ||
                      1920 - hi * 2 > 16 * dv + 16, "duty");
  endtask : t_ref

  task automatic fl_walk(input int stop);
    int last, ec;
    ec = 64;
    last = -1;
    for (int i = 0; i < 3000 && ec > stop; i++) begin
      tick(1);
      if (cell_count_reg !== CELL_W'(ec)) begin
        ec = ec / 2;
        expect_ok(cell_count_reg !== CELL_W'(ec), "cell step");
        expect_ok(cell_en_reg !== {CELLS{1'b1}} >> (CELLS - ec),
                  "cell map");
        if (last >= 0) expect_ok(i - last != 64, "step gap");
        last = i;
        expect_ok(fast_lock_reg !== (ec != 1), "lock flag");
      end
    end
    if (ec > stop) begin
      expect_ok(1'b1, "fast lock hang");
      complete_run();
    end
  endtask : fl_walk

  task automatic t_fl();
    cfg.ref_div = 4'h2;
    cfg.ref_toggle = 1'b0;
    cfg.ref_doubler = 1'b0;
    cfg.pump_current_timer = 10'h003;
    load();
    tick(1);
    expect_ok(cell_count_reg !== CELLS_FULL || cell_en_reg !== {CELLS{1'b1}}
              || fast_lock_reg !== 1'b1, "fast lock start");
    fl_walk(8);
    load();
    tick(1);
    expect_ok(cell_count_reg !== CELLS_FULL, "restart");
    fl_walk(1);
  endtask : t_fl

  task automatic t_fb(input logic [WHOLE_W-1:0] n, input logic hs);
    int g, hits;
    cfg.ref_div = 4'h1;
    cfg.ref_toggle = 1'b1;
    cfg.whole_part = n;
    cfg.numerator_value = 12'h000;
    cfg.presc_hi_sel = hs;
    ref_half = (3 * int'(n) + 2) / 2;
    load();
    hits = 0;
    for (int i = 0; i < 7; i++) begin
      dn_gap(g);
      if (i > 1 && g == int'(n)) hits++;
    end
    expect_ok(hits < 3, "feedback divide");
  endtask : t_fb

  task automatic t_numerator_value();
    int g, sum, odd;
    cfg.denominator_value = 12'h002;
    // Whole part 30 keeps the modulator swing inside the divide range
    cfg.whole_part = 8'h1E;
    cfg.numerator_value = 12'h001;
    cfg.presc_hi_sel = 1'b0;
    // Fast reference keeps up raised, so every done shows a down rise
    ref_half = 4;
    load();
    dn_gap(g);
    dn_gap(g);
    sum = 0;
    odd = 0;
    for (int i = 0; i < 32; i++) begin
      dn_gap(g);
      sum += g;
      if (g != 30) odd++;
    end
    expect_ok(sum < 968 || sum > 984, "fraction average");
    expect_ok(odd == 0, "no modulation");
  endtask : t_numerator_value

  task automatic t_pfd(input int rh, input bit net_up);
    int up_n, dn_n;
    logic bq;
    cfg.numerator_value = 12'h000;
    cfg.whole_part = 8'h1A;
    ref_half = rh;
    load();
    up_n = 0;
    dn_n = 0;
    bq = 1'b0;
    for (int i = 0; i < 4000; i++) begin
      tick(1);
      if (pump_up_reg === 1'b1) up_n++;
      if (pump_dn_reg === 1'b1) dn_n++;
      if (bq === 1'b1) expect_ok(pump_up_reg !== 1'b0 ||
                                 pump_dn_reg !== 1'b0, "joint clear");
      bq = pump_up_reg & pump_dn_reg;
    end
    expect_ok(net_up ? up_n <= dn_n : dn_n <= up_n, "net sign");
  endtask : t_pfd

  task automatic t_pd();
    power_down = 1'b1;
    tick(2);
    expect_ok(ref_path_closed_reg !== 1'b0 ||
              ref_shunt_closed_reg !== 1'b1, "pd switches");
    power_down = 1'b0;
    tick(2);
    expect_ok(ref_path_closed_reg !== 1'b1 ||
              ref_shunt_closed_reg !== 1'b0, "switch restore");
  endtask : t_pd

  // Main sequence
  initial begin
    num_errors = 0;
    checked = 0;
    cfg = '0;
    cfg.whole_part = 8'h1A;
    cfg.ref_div = 4'h1;
    new_freq_load = 1'b0;
    power_down = 1'b0;
    ref_half = 4;
    fb_half = 3;
    sys_rst = 1'b1;
    tick(6);
    sys_rst = 1'b0;
    expect_ok(cell_count_reg !== CELLS_ONE || cell_en_reg !== 64'h1 ||
              fast_lock_reg !== 1'b0, "reset cells");
    expect_ok(pump_up_reg !== 1'b0 || pump_dn_reg !== 1'b0 ||
              ref_path_closed_reg !== 1'b1, "reset pump");
    t_pd();
    t_ref(4'h3, 1'b0, 1'b0, 80);
    t_ref(4'h3, 1'b1, 1'b0, 40);
    t_ref(4'h2, 1'b0, 1'b1, 240);
    t_ref(4'hF, 1'b1, 1'b0, 8);
    t_ref(4'h0, 1'b1, 1'b0, 120);
    t_fl();
    t_fb(8'h1A, 1'b0);
    t_fb(8'h50, 1'b0);
    t_fb(8'h51, 1'b0);
    t_fb(8'h64, 1'b0);
    t_fb(8'hFF, 1'b0);
    t_fb(8'h28, 1'b1);
    t_numerator_value();
    t_pfd(35, 1'b1);
    t_pfd(45, 1'b0);
    complete_run();
  end
endmodule : fractional_n_divider_pfd_tb
